// [hdl/gpe_edge.sv]
// edge detector for one port: compares current and previous synchronised samples
// assumes sample comes from the synchroniser; events are one-cycle pulses
`timescale 1ns/1ps
module gpe_edge
  import gpe_pkg::*;
#(
  parameter int N = PINS
)(
  input  wire logic           sys_clk,
  input  wire logic           reset,
  input  wire logic [N-1:0]   sample,
  input  wire logic [N-1:0]   is_input,
  input  wire logic [2*N-1:0] edge_sel,
  output logic      [N-1:0]   event_pulse
);
  typedef struct packed {
    logic [N-1:0] prev;
    logic         primed;
  } gpe_edge_type;

  gpe_edge_type s_q;
  gpe_edge_type s_d;

  always_comb
  begin
    s_d        = s_q;
    s_d.prev   = sample;
    s_d.primed = 1'b1;
  end

  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  // no compare until one sample is held, so a sample already high in the first cycle after reset gives no event
  for (genvar i = 0; i < N; i++)
  begin : g_pin
    assign event_pulse[i] = s_q.primed & is_input[i] &
      ((edge_sel[2*i+EDGE_RISE_BIT] & sample[i] & ~s_q.prev[i]) |
       (edge_sel[2*i+EDGE_FALL_BIT] & ~sample[i] & s_q.prev[i]));
  end

  a_edge_rise_fires : assert property (@(posedge sys_clk) disable iff (reset)
    s_q.primed && is_input[0] && edge_sel[EDGE_RISE_BIT] && $rose(sample[0])
    |-> event_pulse[0])
    else $error("rising edge on pin 0 gave no event");
  a_edge_output_quiet : assert property (@(posedge sys_clk) disable iff (reset)
    !is_input[N-1] |-> !event_pulse[N-1])
    else $error("output pin produced an event");
endmodule // gpe_edge

// [hdl/gpe_pkg.sv]
// constants shared by the pin port block: register map, field codes, reset values
// assumes a 32-bit avalon-mm slave port and four port instances of sixteen pins
package gpe_pkg;
  localparam int NUM_PORTS = 4;
  localparam int PINS      = 16;
  localparam int GLOB_PORT = 2;
  localparam int GLOB_BITS = 8;
  localparam int ADDR_W    = 8;

  // byte offsets inside one port window; the window index is address[7:6]
  localparam logic [5:0] OFF_DIR      = 6'h00;
  localparam logic [5:0] OFF_DATA_IN  = 6'h04;
  localparam logic [5:0] OFF_DATA_OUT = 6'h08;
  localparam logic [5:0] OFF_OUT_SET  = 6'h0c;
  localparam logic [5:0] OFF_OUT_CLR  = 6'h10;
  localparam logic [5:0] OFF_EDGE     = 6'h14;
  localparam logic [5:0] OFF_MASK     = 6'h18;
  localparam logic [5:0] OFF_MASK_SET = 6'h1c;
  localparam logic [5:0] OFF_MASK_CLR = 6'h20;
  localparam logic [5:0] OFF_PEND     = 6'h24;
  localparam logic [5:0] OFF_MODE     = 6'h28;

  // edge select, two bits per pin: bit 0 rising, bit 1 falling
  localparam int EDGE_RISE_BIT = 0;
  localparam int EDGE_FALL_BIT = 1;
  localparam int MODE_IDLE_BIT = 0;

  localparam logic [15:0] DIR_RST  = 16'hffff;
  localparam logic [15:0] OUT_RST  = 16'h0000;
  localparam logic [15:0] MASK_RST = 16'hffff;
  localparam logic [31:0] EDGE_RST = 32'h0000_0000;
  localparam logic        MODE_RST = 1'b0;
endpackage

// [hdl/gpe_sync.sv]
// two-stage synchroniser for the pad inputs
// assumes pins change freely; only the second stage may be looked at
`timescale 1ns/1ps
module gpe_sync
  import gpe_pkg::*;
#(
  parameter int W = NUM_PORTS * PINS
)(
  input  wire logic         sys_clk,
  input  wire logic         reset,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } gpe_sync_type;

  gpe_sync_type s_q;
  gpe_sync_type s_d;

  always_comb
  begin
    s_d        = s_q;
    s_d.meta   = async_in;
    s_d.stable = s_q.meta;
  end

  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign sync_out = s_q.stable;

  a_sync_two_stage : assert property (@(posedge sys_clk) disable iff (reset)
    $past(reset, 2) == 1'b0 |-> sync_out == $past(async_in, 2))
    else $error("synchroniser delay is not two cycles");
endmodule // gpe_sync

// [hdl/gpe_top.sv]
// four pin ports with edge events behind one avalon-mm slave
// assumes pins are synchronised here; waitrequest answers one cycle after a request
`timescale 1ns/1ps
module gpe_top
  import gpe_pkg::*;
(
  input  wire logic                      sys_clk,
  input  wire logic                      reset,
  input  wire logic [ADDR_W-1:0]         avs_address,
  input  wire logic                      avs_read,
  input  wire logic                      avs_write,
  input  wire logic [31:0]               avs_writedata,
  input  wire logic [3:0]                avs_byteenable,
  output logic      [31:0]               avs_readdata,
  output logic                           avs_waitrequest,
  input  wire logic [NUM_PORTS*PINS-1:0] pin_in,
  output logic      [NUM_PORTS*PINS-1:0] pin_out,
  output logic      [NUM_PORTS*PINS-1:0] pin_oe_n,
  output logic      [NUM_PORTS-1:0]      irq,
  output logic      [NUM_PORTS-1:0]      wake,
  output logic                           global_out
);
  typedef struct packed {
    logic [NUM_PORTS-1:0][PINS-1:0]   dir;
    logic [NUM_PORTS-1:0][PINS-1:0]   data_out;
    logic [NUM_PORTS-1:0][PINS-1:0]   mask;
    logic [NUM_PORTS-1:0][PINS-1:0]   pend;
    logic [NUM_PORTS-1:0][2*PINS-1:0] edge_sel;
    logic [NUM_PORTS-1:0]             idle;
    logic [NUM_PORTS-1:0]             irq;
    logic [NUM_PORTS-1:0]             wake;
    logic                             glob;
    logic                             wait_req;
    logic [31:0]                      rdata;
  } gpe_state_type;

  gpe_state_type s_q;
  gpe_state_type s_d;

  logic [NUM_PORTS-1:0][PINS-1:0] in_sync;
  logic [NUM_PORTS-1:0][PINS-1:0] ev;

  // byte enables widened to a bit mask
  function automatic logic [31:0] be_mask(input logic [3:0] be);
    logic [31:0] m;
    m = '0;
    for (int b = 0; b < 4; b++)
    begin
      m[8*b +: 8] = {8{be[b]}};
    end
    return m;
  endfunction

  // a plain write: only enabled byte lanes change
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] wd,
                                        input logic [31:0] wm);
    return (old & ~wm) | (wd & wm);
  endfunction

  gpe_sync #(
    .W (NUM_PORTS * PINS)
  ) u_sync (
    .sys_clk  (sys_clk),
    .reset    (reset),
    .async_in (pin_in),
    .sync_out (in_sync)
  );

  for (genvar p = 0; p < NUM_PORTS; p++)
  begin : g_port
    gpe_edge #(
      .N (PINS)
    ) u_edge (
      .sys_clk     (sys_clk),
      .reset       (reset),
      .sample      (in_sync[p]),
      .is_input    (s_q.dir[p]),
      .edge_sel    (s_q.edge_sel[p]),
      .event_pulse (ev[p])
    );
  end

  logic [1:0]  port_sel;
  logic [5:0]  off;
  logic [31:0] wm;
  logic [31:0] wd;
  logic        req;
  logic        take;

  assign port_sel = avs_address[7:6];
  assign off      = avs_address[5:0];
  assign wm       = be_mask(avs_byteenable);
  assign wd       = avs_writedata & wm;
  assign req      = avs_read | avs_write;
  assign take     = req & ~s_q.wait_req;

  always_comb
  begin
    s_d = s_q;

    // bus handshake: first edge of a request lowers waitrequest for one cycle
    s_d.wait_req = ~(req & s_q.wait_req);
    if (req && s_q.wait_req)
    begin
      s_d.rdata = '0;
      if (avs_read)
      begin
        if (off == OFF_DIR)
          s_d.rdata = {16'h0000, s_q.dir[port_sel]};
        else if (off == OFF_DATA_IN)
          s_d.rdata = {16'h0000, in_sync[port_sel]};
        else if (off == OFF_DATA_OUT)
          s_d.rdata = {16'h0000, s_q.data_out[port_sel]};
        else if (off == OFF_EDGE)
          s_d.rdata = s_q.edge_sel[port_sel];
        else if (off == OFF_MASK)
          s_d.rdata = {16'h0000, s_q.mask[port_sel]};
        else if (off == OFF_PEND)
          s_d.rdata = {16'h0000, s_q.pend[port_sel]};
        else if (off == OFF_MODE)
          s_d.rdata = {31'h0000_0000, s_q.idle[port_sel]};
        else
          s_d.rdata = '0; // unmapped and write-only offsets read zero
      end
    end

    // writes take effect on the edge where waitrequest is seen low
    if (take && avs_write)
    begin
      if (off == OFF_DIR)
        s_d.dir[port_sel] = 16'(merge({16'h0000, s_q.dir[port_sel]}, wd, wm));
      else if (off == OFF_DATA_OUT)
        s_d.data_out[port_sel] = 16'(merge({16'h0000, s_q.data_out[port_sel]}, wd, wm));
      else if (off == OFF_OUT_SET)
        s_d.data_out[port_sel] = s_q.data_out[port_sel] | wd[15:0];
      else if (off == OFF_OUT_CLR)
        s_d.data_out[port_sel] = s_q.data_out[port_sel] & ~wd[15:0];
      else if (off == OFF_EDGE)
        s_d.edge_sel[port_sel] = merge(s_q.edge_sel[port_sel], wd, wm);
      else if (off == OFF_MASK)
        s_d.mask[port_sel] = 16'(merge({16'h0000, s_q.mask[port_sel]}, wd, wm));
      else if (off == OFF_MASK_SET)
        s_d.mask[port_sel] = s_q.mask[port_sel] | wd[15:0];
      else if (off == OFF_MASK_CLR)
        s_d.mask[port_sel] = s_q.mask[port_sel] & ~wd[15:0];
      else if (off == OFF_PEND)
        s_d.pend[port_sel] = s_q.pend[port_sel] & ~wd[15:0];
      else if (off == OFF_MODE)
      begin
        if (avs_byteenable[0])
          s_d.idle[port_sel] = avs_writedata[MODE_IDLE_BIT];
      end
    end

    // a fresh event beats a clear written in the same cycle
    for (int p = 0; p < NUM_PORTS; p++)
    begin
      s_d.pend[p] = s_d.pend[p] | ev[p];
      s_d.irq[p]  = ~s_q.idle[p] & (|(s_q.pend[p] & ~s_q.mask[p]));
      s_d.wake[p] = s_q.idle[p] & (|(s_q.pend[p] & ~s_q.mask[p]));
    end

    s_d.glob = |s_q.data_out[GLOB_PORT][GLOB_BITS-1:0];
  end

  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      s_q          <= '0;
      s_q.dir      <= {NUM_PORTS{DIR_RST}};
      s_q.data_out <= {NUM_PORTS{OUT_RST}};
      s_q.mask     <= {NUM_PORTS{MASK_RST}};
      s_q.edge_sel <= {NUM_PORTS{EDGE_RST}};
      s_q.idle     <= {NUM_PORTS{MODE_RST}};
      s_q.wait_req <= 1'b1;
    end
    else
      s_q <= s_d;
  end

  // a set direction bit means input, so the pad driver is off
  assign pin_out         = s_q.data_out;
  assign pin_oe_n        = s_q.dir;
  assign irq             = s_q.irq;
  assign wake            = s_q.wake;
  assign global_out      = s_q.glob;
  assign avs_readdata    = s_q.rdata;
  assign avs_waitrequest = s_q.wait_req;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  a_irq_active_merge : assert property (
    !s_q.idle[0] && |(s_q.pend[0] & ~s_q.mask[0]) |=> irq[0])
    else $error("active mode pending event gave no interrupt");
  a_idle_no_irq : assert property (
    s_q.idle[1] |=> !irq[1])
    else $error("interrupt raised in idle mode");
  a_idle_wake_line : assert property (
    s_q.idle[3] && |(s_q.pend[3] & ~s_q.mask[3]) |=> wake[3] && !irq[3])
    else $error("idle mode pending event gave no wake-up");
  a_mask_blocks_irq : assert property (
    (s_q.pend[2] & ~s_q.mask[2]) == 16'h0000 |=> !irq[2] && !wake[2])
    else $error("masked pin reached the interrupt");
  a_global_or_lines : assert property (
    ##1 global_out == |$past(s_q.data_out[GLOB_PORT][GLOB_BITS-1:0]))
    else $error("global line is not the OR of eight output lines");
  a_event_latches : assert property (
    ev[0] != 16'h0000 |=> (s_q.pend[0] & $past(ev[0])) == $past(ev[0]))
    else $error("event lost from pending flags");
  a_set_keeps_others : assert property (
    take && avs_write && off == OFF_OUT_SET && port_sel == 2'h0
    |=> pin_out[15:0] == ($past(pin_out[15:0]) | $past(wd[15:0])))
    else $error("output set write disturbed other bits");
  a_clr_mask_bits : assert property (
    take && avs_write && off == OFF_MASK_CLR && port_sel == 2'h0
    |=> s_q.mask[0] == ($past(s_q.mask[0]) & ~$past(wd[15:0])))
    else $error("mask clear write disturbed other bits");
  a_dir_to_pad : assert property (
    take && avs_write && off == OFF_DIR && port_sel == 2'h1 && avs_byteenable[0]
    |=> pin_oe_n[23:16] == $past(avs_writedata[7:0]))
    else $error("direction write did not reach pad enable");
  a_irq_holds_pend : assert property (
    irq[0] && !$past(s_q.idle[0]) && |(s_q.pend[0] & ~s_q.mask[0]) && !s_q.idle[0]
    |=> irq[0])
    else $error("interrupt dropped while unmasked flag pending");
  a_wait_one_low : assert property (
    !avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");

  c_irq_rise : cover property ($rose(irq[0]));
  c_wake_rise : cover property ($rose(wake[3]));
  c_global_high : cover property ($rose(global_out));
  c_pend_cleared : cover property (take && avs_write && off == OFF_PEND && wd != '0);
endmodule // gpe_top

// [test/gpe_pad_model.sv]
// pad model: board levels on input pads, dut drive seen back on output pads
// assumes pin_oe_n low means the dut drives the pad
`timescale 1ns/1ps
module gpe_pad_model
  import gpe_pkg::*;
(
  input  wire logic [NUM_PORTS*PINS-1:0] pin_out,
  input  wire logic [NUM_PORTS*PINS-1:0] pin_oe_n,
  input  wire logic [NUM_PORTS*PINS-1:0] ext_level,
  output logic      [NUM_PORTS*PINS-1:0] pin_in
);
  // the board level wins only where the dut lets the pad go
  assign pin_in = (pin_oe_n & ext_level) | (~pin_oe_n & pin_out);
endmodule // gpe_pad_model

// [test/gpe_tb_top.sv]
// testbench for the pin port block: avalon-mm register tasks and pad stimulus
// assumes one clock, waitrequest answers each request, pads via the pad model
`timescale 1ns/1ps
module gpe_tb_top
  import gpe_pkg::*;
;
  logic                      sys_clk;
  logic                      reset;
  logic [ADDR_W-1:0]         avs_address;
  logic                      avs_read;
  logic                      avs_write;
  logic [31:0]               avs_writedata;
  logic [3:0]                avs_byteenable;
  logic [31:0]               avs_readdata;
  logic                      avs_waitrequest;
  logic [NUM_PORTS*PINS-1:0] pin_in;
  logic [NUM_PORTS*PINS-1:0] pin_out;
  logic [NUM_PORTS*PINS-1:0] pin_oe_n;
  logic [NUM_PORTS*PINS-1:0] ext_level;
  logic [NUM_PORTS-1:0]      irq;
  logic [NUM_PORTS-1:0]      wake;
  logic                      global_out;
  logic [31:0]               rdata;
  int                        miscompares;
  int                        samples_checked;
  int                        cycles;

  gpe_top dut (.sys_clk(sys_clk), .reset(reset), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe_n(pin_oe_n), .irq(irq), .wake(wake), .global_out(global_out));

  gpe_pad_model pads (.pin_out(pin_out), .pin_oe_n(pin_oe_n),
    .ext_level(ext_level), .pin_in(pin_in));

  initial sys_clk = 1'b0;
  always #25 sys_clk = ~sys_clk;

  function automatic logic [7:0] ad(input logic [1:0] p, input logic [5:0] o);
    return {p, o};
  endfunction

  task automatic complete_run();
    $display("checked %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // a hang in a bus wait lands here instead of running forever
  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      miscompares++;
      complete_run();
    end
  end

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    samples_checked++;
    if (s !== e)
    begin
      $display("[FAIL] %s expected %h seen %h", n, e, s);
      miscompares++;
    end
  endtask

  // request held until the edge that samples waitrequest low
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= 1'b1;
    do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
    avs_write <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge sys_clk);
    avs_address <= a;
    avs_read <= 1'b1;
    do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
    rdata = avs_readdata;
    avs_read <= 1'b0;
  endtask

  // pads need two sync stages and the pend/irq registers; the edge compare adds no stage
  task automatic settle(input int n);
    repeat (n) @(negedge sys_clk);
  endtask

  initial
  begin
    reset = 1'b1;
    avs_address = '0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = '0;
    avs_byteenable = 4'hf;
    ext_level = '0;
    miscompares = 0;
    samples_checked = 0;
    cycles = 0;
    repeat (20) @(posedge sys_clk);
    reset <= 1'b0;
    rd(ad(0, OFF_DIR)); chk("dir_rst", {16'h0000, DIR_RST}, rdata);
    rd(ad(0, OFF_MASK)); chk("mask_rst", {16'h0000, MASK_RST}, rdata);
    rd(ad(0, OFF_DATA_OUT)); chk("out_rst", {16'h0000, OUT_RST}, rdata);
    rd(ad(0, OFF_EDGE)); chk("edge_rst", EDGE_RST, rdata);
    rd(ad(3, 6'h3c)); chk("unmapped", 32'h0000_0000, rdata);
    wr(ad(1, OFF_DIR), 32'h0000_00ff);
    // both edges on every pin, so only the direction bit keeps output pins quiet
    wr(ad(1, OFF_EDGE), 32'hffff_ffff);
    ext_level[31:16] <= 16'h1234;
    wr(ad(1, OFF_DATA_OUT), 32'h0000_a5a5);
    settle(4);
    rd(ad(1, OFF_DATA_IN)); chk("data_in", 32'h0000_a534, rdata);
    rd(ad(1, OFF_PEND)); chk("pend_out_pins", 32'h0000_0034, rdata);
    avs_byteenable <= 4'h1;
    wr(ad(3, OFF_DIR), 32'h0000_0000);
    avs_byteenable <= 4'hf;
    rd(ad(3, OFF_DIR)); chk("dir_lane", 32'h0000_ff00, rdata);
    settle(1); chk("oe_n", 32'h00ff_ffff, pin_oe_n[31:0]);
    wr(ad(0, OFF_DATA_OUT), 32'h0000_0f00);
    wr(ad(0, OFF_OUT_SET), 32'h0000_00f0);
    wr(ad(0, OFF_OUT_CLR), 32'h0000_0300);
    rd(ad(0, OFF_DATA_OUT)); chk("out_setclr", 32'h0000_0cf0, rdata);
    wr(ad(0, OFF_MASK_CLR), 32'h0000_00ff);
    wr(ad(0, OFF_MASK_SET), 32'h0000_0002);
    rd(ad(0, OFF_MASK)); chk("mask_setclr", 32'h0000_ff02, rdata);
    wr(ad(2, OFF_DATA_OUT), 32'h0000_ff00);
    settle(2); chk("glob_low", 32'h0, 32'(global_out));
    wr(ad(2, OFF_OUT_SET), 32'h0000_0080);
    settle(2); chk("glob_high", 32'h1, 32'(global_out));
    // pin 0 of port 0 stays an input, as any wake-up pin must
    for (int m = 1; m < 4; m++)
    begin
      wr(ad(0, OFF_EDGE), 32'(m));
      ext_level[0] <= 1'b1;
      settle(6); chk("irq_rise", 32'(m & 1), 32'(irq));
      rd(ad(0, OFF_PEND)); chk("pend_rise", 32'(m & 1), rdata);
      wr(ad(0, OFF_PEND), 32'h0000_0001);
      settle(2); chk("irq_clr", 32'h0, 32'(irq));
      @(posedge sys_clk);
      ext_level[0] <= 1'b0;
      settle(6);
      rd(ad(0, OFF_PEND)); chk("pend_fall", 32'(m >> 1), rdata);
      wr(ad(0, OFF_PEND), 32'h0000_0001);
    end
    wr(ad(0, OFF_EDGE), 32'h0000_000c);
    ext_level[1] <= 1'b1;
    settle(6); chk("irq_masked", 32'h0, 32'(irq));
    rd(ad(0, OFF_PEND)); chk("pend_masked", 32'h0000_0002, rdata);
    wr(ad(0, OFF_PEND), 32'h0000_0002);
    wr(ad(0, OFF_EDGE), 32'h0000_0001);
    wr(ad(0, OFF_MODE), 32'h0000_0001);
    ext_level[0] <= 1'b1;
    settle(6); chk("idle_wake", 32'h0000_0001, {irq, wake});
    complete_run();
  end
endmodule // gpe_tb_top
